/* shared/acbx_regs.svh */
`ifndef ACBX_REGS_SVH
`define ACBX_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ACBX_OFS_INSTR 8'h00
`define ACBX_OFS_ACC 8'h04
`define ACBX_OFS_FLAGS 8'h08
`define ACBX_OFS_BANK 8'h0C
`define ACBX_OFS_PC 8'h10
`define ACBX_OFS_STATE 8'h14

// ****************************************
// Flag bit positions
// ****************************************
`define ACBX_FLAG_C 0
`define ACBX_FLAG_HALF_CARRY 1
`define ACBX_FLAG_Z 2
`define ACBX_FLAG_RANGE 3
`define ACBX_FLAG_N 4

// ****************************************
// State register bits
// ****************************************
`define ACBX_ST_BUSY 0
`define ACBX_ST_BAD 1
`define ACBX_ST_TAKEN 2

// ****************************************
// Opcode fields
// ****************************************
`define ACBX_OPC_ADD_IMM 8'h0F
`define ACBX_OPC_AND_IMM 8'h0B
`define ACBX_OPC_BRANCH_C 8'hE2
`define ACBX_OPC_ADD_FILE 6'h09
`define ACBX_OPC_ADDC_FILE 6'h08
`define ACBX_OPC_AND_FILE 6'h05

// ****************************************
// Banking, widths and reset values
// ****************************************
`define ACBX_ACCESS_SPLIT 8'h80
`define ACBX_ACCESS_LO_BANK 4'h0
`define ACBX_ACCESS_HI_BANK 4'hF
`define ACBX_PC_STEP 21'h000002
`define ACBX_RST_BYTE 8'h00
`define ACBX_RST_FLAGS 5'h00
`define ACBX_RST_BANK 4'h0
`define ACBX_RST_PC 21'h000000
`define ACBX_RST_INSTR 16'h0000
`define ACBX_RST_WORD 32'h00000000
`define ACBX_RST_ADDR 12'h000
`define ACBX_RST_QUARTER 2'h0
`define ACBX_QUARTER_LAST 2'h3
`define ACBX_AHB_NONSEQ_BIT 1

`endif

/* shared/acbx_pkg.sv */
`default_nettype none

package acbx_pkg;
	typedef enum {ACBX_IDLE, ACBX_Q1, ACBX_Q2, ACBX_Q3, ACBX_Q4, ACBX_NOP}
		acbx_state_t;
	typedef enum {ACBX_OP_ADD_IMM, ACBX_OP_ADD_FILE, ACBX_OP_ADDC_FILE,
		ACBX_OP_AND_IMM, ACBX_OP_AND_FILE, ACBX_OP_BRANCH_C,
		ACBX_OP_BAD} acbx_op_t;
endpackage : acbx_pkg

`default_nettype wire

/* hw/acbx_core.sv */
// Notes on behaviour
// - Add accumulator to file, d picks destination
// - Bank bit 0 access bank, 1 bank select
// - Add with carry sums accumulator, file, carry
// - Carry is third operand, file address operand
// - Carry add with d=1 writes file
// - Adds update all five flags, one cycle
// - AND immediate into accumulator, sets N Z
// - AND immediate opcode 0000 1011 kkkk kkkk
// - AND file to chosen destination, sets N Z
// - AND file opcode 0001 01da ffff ffff
// - Branch only on carry set, flags untouched
// - Offset is signed field doubled, two's complement
// - Taken: PC plus two plus offset, two cycles
// - Branch opcode 1110 0010 nnnn nnnn
`include "acbx_regs.svh"
`default_nettype none

module acbx_core
	import acbx_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [11:0] file_addr,
	output logic file_re,
	input wire logic [7:0] file_rdata,
	output logic file_we,
	output logic [7:0] file_wdata
);

	// ****************************************
	// Arithmetic helpers
	// ****************************************
	// Returns {half carry, carry, sum}
	function automatic logic [9:0] acbx_add(input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		acbx_add = {h[4], s};
	endfunction

	// Returns {negative, zero}
	function automatic logic [1:0] acbx_nz(input logic [7:0] r);
		acbx_nz = {r[7], r == `ACBX_RST_BYTE};
	endfunction

	// ****************************************
	// Bus slave
	// ****************************************
	acbx_state_t state;
	acbx_state_t next_state;
	acbx_op_t op;
	logic dp_write;
	logic [7:0] dp_addr;
	logic [15:0] instr;
	logic [7:0] acc;
	logic [4:0] flags;
	logic [3:0] bank;
	logic [20:0] pc;
	logic [7:0] operand;
	logic [7:0] result;
	logic [4:0] res_flags;
	logic taken;
	logic bad_op;
	logic [1:0] nop_q;

	wire addr_phase = hsel & htrans[`ACBX_AHB_NONSEQ_BIT] & hready;
	wire idle = state == ACBX_IDLE;
	wire wr_instr = dp_write & (dp_addr == `ACBX_OFS_INSTR) & idle;
	wire wr_acc = dp_write & (dp_addr == `ACBX_OFS_ACC) & idle;
	wire wr_flags = dp_write & (dp_addr == `ACBX_OFS_FLAGS) & idle;
	wire wr_bank = dp_write & (dp_addr == `ACBX_OFS_BANK) & idle;
	wire wr_pc = dp_write & (dp_addr == `ACBX_OFS_PC) & idle;
	wire [7:0] ap_addr = {haddr[7:2], 2'b00};
	wire [2:0] state_bits = {taken, bad_op, ~idle};
	wire [31:0] rd_mux =
		(ap_addr == `ACBX_OFS_INSTR) ? {16'h0000, instr} :
		(ap_addr == `ACBX_OFS_ACC) ? {24'h000000, acc} :
		(ap_addr == `ACBX_OFS_FLAGS) ? {27'h0000000, flags} :
		(ap_addr == `ACBX_OFS_BANK) ? {28'h0000000, bank} :
		(ap_addr == `ACBX_OFS_PC) ? {11'h000, pc} :
		(ap_addr == `ACBX_OFS_STATE) ? {29'h00000000, state_bits} :
		32'h00000000;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_write <= 1'b0;
			dp_addr <= `ACBX_RST_BYTE;
		end
		else
		begin
			dp_write <= addr_phase & hwrite;
			dp_addr <= ap_addr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= `ACBX_RST_WORD;
		else if (addr_phase & ~hwrite)
			hrdata <= rd_mux;
	end

	// ****************************************
	// Decode
	// ****************************************
	wire dest_bit = instr[9];
	wire bank_bit = instr[8];
	wire [7:0] field = instr[7:0];
	wire is_add_imm = instr[15:8] == `ACBX_OPC_ADD_IMM;
	wire is_and_imm = instr[15:8] == `ACBX_OPC_AND_IMM;
	wire is_branch = instr[15:8] == `ACBX_OPC_BRANCH_C;
	wire is_add_file = instr[15:10] == `ACBX_OPC_ADD_FILE;
	wire is_addc_file = instr[15:10] == `ACBX_OPC_ADDC_FILE;
	wire is_and_file = instr[15:10] == `ACBX_OPC_AND_FILE;
	wire uses_file = (op == ACBX_OP_ADD_FILE) |
		(op == ACBX_OP_ADDC_FILE) | (op == ACBX_OP_AND_FILE);
	wire uses_imm = (op == ACBX_OP_ADD_IMM) | (op == ACBX_OP_AND_IMM);
	wire [11:0] access_addr = (field < `ACBX_ACCESS_SPLIT) ?
		{`ACBX_ACCESS_LO_BANK, field} : {`ACBX_ACCESS_HI_BANK, field};
	wire [11:0] data_addr = bank_bit ? {bank, field} : access_addr;
	wire [20:0] branch_ofs = {{12{field[7]}}, field, 1'b0};
	wire [20:0] pc_next = pc + `ACBX_PC_STEP;
	wire [20:0] pc_target = pc_next + branch_ofs;

	// ****************************************
	// Process
	// ****************************************
	wire carry_in = (op == ACBX_OP_ADDC_FILE) & flags[`ACBX_FLAG_C];
	wire [9:0] add_out = acbx_add(acc, operand, carry_in);
	wire [7:0] and_out = acc & operand;
	wire is_and = (op == ACBX_OP_AND_IMM) | (op == ACBX_OP_AND_FILE);
	wire is_add = (op == ACBX_OP_ADD_IMM) | (op == ACBX_OP_ADD_FILE) |
		(op == ACBX_OP_ADDC_FILE);
	wire [7:0] alu_out = is_and ? and_out : add_out[7:0];
	wire [1:0] nz = acbx_nz(alu_out);
	wire add_ov = (acc[7] == operand[7]) & (add_out[7] != acc[7]);
	wire [4:0] add_flags = {nz[1], add_ov, nz[0], add_out[9], add_out[8]};
	wire [4:0] and_flags = {nz[1], flags[`ACBX_FLAG_RANGE], nz[0],
		flags[`ACBX_FLAG_HALF_CARRY], flags[`ACBX_FLAG_C]};
	wire [4:0] proc_flags = is_add ? add_flags :
		is_and ? and_flags : flags;
	wire write_file = uses_file & dest_bit;
	wire write_acc = is_add | is_and;

	// ****************************************
	// Quarter sequencer
	// ****************************************
	always_comb
	begin
		next_state = state;
		case (state)
			ACBX_IDLE:
				if (wr_instr)
					next_state = ACBX_Q1;
			ACBX_Q1:
				next_state = ACBX_Q2;
			ACBX_Q2:
				next_state = ACBX_Q3;
			ACBX_Q3:
				next_state = ACBX_Q4;
			ACBX_Q4:
				next_state = taken ? ACBX_NOP : ACBX_IDLE;
			ACBX_NOP:
				if (nop_q == `ACBX_QUARTER_LAST)
					next_state = ACBX_IDLE;
			default:
				next_state = ACBX_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state <= ACBX_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			nop_q <= `ACBX_RST_QUARTER;
		else if (state == ACBX_NOP)
			nop_q <= nop_q + 2'h1;
		else
			nop_q <= `ACBX_RST_QUARTER;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			instr <= `ACBX_RST_INSTR;
		else if (wr_instr)
			instr <= hwdata[15:0];
	end

	// Decode in the first quarter
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			op <= ACBX_OP_BAD;
		else if (state == ACBX_Q1)
		begin
			if (is_add_imm)
				op <= ACBX_OP_ADD_IMM;
			else if (is_and_imm)
				op <= ACBX_OP_AND_IMM;
			else if (is_branch)
				op <= ACBX_OP_BRANCH_C;
			else if (is_add_file)
				op <= ACBX_OP_ADD_FILE;
			else if (is_addc_file)
				op <= ACBX_OP_ADDC_FILE;
			else if (is_and_file)
				op <= ACBX_OP_AND_FILE;
			else
				op <= ACBX_OP_BAD;
		end
	end

	// ****************************************
	// File register port
	// ****************************************
	assign file_re = (state == ACBX_Q2) & uses_file;
	assign file_we = (state == ACBX_Q4) & write_file;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			file_addr <= `ACBX_RST_ADDR;
		else if (state == ACBX_Q1)
			file_addr <= data_addr;
	end

	// Operand read in the second quarter
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			operand <= `ACBX_RST_BYTE;
		else if (state == ACBX_Q2)
			operand <= uses_imm ? field : file_rdata;
	end

	// Processing in the third quarter
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			result <= `ACBX_RST_BYTE;
			res_flags <= `ACBX_RST_FLAGS;
		end
		else if (state == ACBX_Q3)
		begin
			result <= alu_out;
			res_flags <= proc_flags;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			file_wdata <= `ACBX_RST_BYTE;
		else if (state == ACBX_Q3)
			file_wdata <= alu_out;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			taken <= 1'b0;
			bad_op <= 1'b0;
		end
		else if (state == ACBX_Q3)
		begin
			taken <= (op == ACBX_OP_BRANCH_C) & flags[`ACBX_FLAG_C];
			bad_op <= op == ACBX_OP_BAD;
		end
	end

	// ****************************************
	// Write back in the fourth quarter
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			acc <= `ACBX_RST_BYTE;
		else if (wr_acc)
			acc <= hwdata[7:0];
		else if ((state == ACBX_Q4) & write_acc & ~write_file)
			acc <= result;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flags <= `ACBX_RST_FLAGS;
		else if (wr_flags)
			flags <= hwdata[4:0];
		else if (state == ACBX_Q4)
			flags <= res_flags;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			bank <= `ACBX_RST_BANK;
		else if (wr_bank)
			bank <= hwdata[3:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pc <= `ACBX_RST_PC;
		else if (wr_pc)
			pc <= hwdata[20:0];
		else if (state == ACBX_Q4)
			pc <= taken ? pc_target : pc_next;
	end

endmodule // acbx_core

`default_nettype wire

/* verification/acbx_core_properties.sv */
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module acbx_core_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [11:0] file_addr,
	input wire logic file_re,
	input wire logic file_we
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_okay_resp: assert property (!hresp)
		else $error("hresp not okay");
	a_re_gap: assert property (file_re |=> !file_re [*4])
		else $error("file read too soon");
	a_we_single: assert property (file_we |=> !file_we)
		else $error("file write too long");
	a_we_after_re: assert property (file_we |-> $past(file_re, 2))
		else $error("file write without read");
	a_re_we_apart: assert property (file_re |-> !file_we)
		else $error("read and write together");
	a_addr_held: assert property (file_re |=> $stable(file_addr) [*2])
		else $error("file address moved");
	a_we_addr: assert property (file_we |->
		file_addr == $past(file_addr, 2)) else $error("write address");
	cover property (file_re);
	cover property (file_we);
	cover property (file_re ##2 !file_we);
endmodule // acbx_core_checker

bind acbx_core acbx_core_checker i_checker (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .file_addr(file_addr),
	.file_re(file_re), .file_we(file_we));
`default_nettype wire

/* verification/test_add_and_carry_branch_exec.sv */
`default_nettype none
// ****************************************
// Bench
// ****************************************
module test_add_and_carry_branch_exec;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, file_re, file_we;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [11:0] file_addr;
	logic [7:0] file_rdata, file_wdata;
	logic [7:0] mem [4096];
	logic [7:0] up [7] = '{8'h0F, 8'h0B, 8'hE2, 8'h24, 8'h20, 8'h14, 8'hFF};
	int n_mismatch, samples_checked, cyc;
	acbx_core i_acbx_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .file_addr(file_addr),
		.file_re(file_re), .file_rdata(file_rdata), .file_we(file_we),
		.file_wdata(file_wdata));
	// Data memory, scrambled when not read
	assign file_rdata = file_re ? mem[file_addr] : ~mem[file_addr];
	always @(posedge hclk)
	begin
		if (file_we === 1'b1)
			mem[file_addr] <= file_wdata;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			tally_and_finish;
		end
	end
	initial
	begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	// Expected flags of an add: sign, range, zero, half carry, carry
	function automatic logic [4:0] add_flags_of(input logic [7:0] x,
		input logic [7:0] y, input logic [7:0] r, input logic cy,
		input logic hc);
		add_flags_of = {r[7], x[7] == y[7] && r[7] != x[7], r == 8'h00,
			hc, cy};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		if (w)
			@(posedge hclk);
	endtask
	task automatic run(input int i);
		logic [7:0] acc, f, opd, res;
		logic [4:0] fl, h;
		logic [3:0] bank;
		logic [20:0] pc;
		logic [11:0] adr;
		logic [8:0] s;
		logic d, a, c, fo, tk, nd;
		int k, n;
		k = i % 7;
		acc = $urandom;
		fl = $urandom;
		bank = $urandom;
		pc = $urandom;
		f = (i % 5 == 0) ? 8'h7F + i[3] : $urandom;
		d = $urandom;
		a = $urandom;
		fo = k > 2 && k < 6;
		nd = k == 1 || k == 5;
		adr = a ? {bank, f} : {{4{f[7]}}, f};
		opd = fo ? mem[adr] : f;
		c = k == 4 && fl[0];
		s = acc + opd + c;
		h = acc[3:0] + opd[3:0] + c;
		res = nd ? acc & opd : s[7:0];
		tk = k == 2 && fl[0];
		bus(1'b1, 8'h04, acc);
		bus(1'b1, 8'h08, fl);
		bus(1'b1, 8'h0C, bank);
		bus(1'b1, 8'h10, pc);
		bus(1'b1, 8'h00, {up[k] | (fo ? {6'h0, d, a} : 8'h00), f});
		bus(1'b1, 8'h04, ~acc);
		if (k == 0 || k == 3 || k == 4)
			fl = add_flags_of(acc, opd, res, s[8], h[4]);
		if (nd)
			fl = {res[7], fl[3], res == 8'h00, fl[1:0]};
		if (k < 2 || (fo && !d))
			acc = res;
		pc = pc + 21'h2 + (tk ? {{12{f[7]}}, f, 1'b0} : 21'h0);
		n = 0;
		do
		begin
			bus(1'b0, 8'h14, 32'h0);
			n++;
		end
		while (q[0] !== 1'b0 && n < 20);
		chk(n, tk ? 3 : 1);
		chk(q[1:0], {k == 6, 1'b0});
		if (k == 2)
			chk(q[2], tk);
		bus(1'b0, 8'h04, 32'h0);
		chk(q, acc);
		bus(1'b0, 8'h08, 32'h0);
		chk(q, fl);
		bus(1'b0, 8'h10, 32'h0);
		chk(q, pc);
		if (fo && d)
			chk(mem[adr], res);
	endtask
	task automatic tally_and_finish;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		n_mismatch = 0;
		samples_checked = 0;
		q = $urandom(32'hC4A9);
		for (int i = 0; i < 4096; i++)
			mem[i] = $urandom;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b1, 8'h18, 32'hFFFFFFFF);
		for (int r = 0; r < 32; r += 4)
		begin
			bus(1'b0, r[7:0], 32'h0);
			chk(q, 32'h0);
		end
		for (int i = 0; i < 210; i++)
			run(i);
		tally_and_finish;
	end
endmodule // test_add_and_carry_branch_exec
`default_nettype wire
